// ---- hw/rssa_alu.sv ----
// combinational operation unit: result byte, destination, flags, skip
`timescale 1ns/1ps
`default_nettype none
`include "rssa_params.svh"

module rssa_alu
(
  input  wire logic                   [7:0] mem_byte,
  input  wire logic                   [7:0] wreg,
  input  wire logic                   [7:0] imm,
  input  wire logic                   [2:0] bit_sel,
  input  wire rssa_pkg::rssa_op_t           op,
  input  wire rssa_pkg::rssa_flags_t        flags,
  output rssa_pkg::rssa_alu_res_t           res
);

  logic       borrow_in;
  logic [7:0] sub_b;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic [7:0] bit_mask;

  assign sub_b     = (op == rssa_pkg::OP_MINUS_IMM) ? imm : mem_byte; // RQ11
  assign borrow_in = ((op == rssa_pkg::OP_SUB_BORROW_W) || (op == rssa_pkg::OP_SUB_BORROW_M)) & ~flags.c; // RQ8
  assign diff      = {1'b0, wreg} - {1'b0, sub_b} - {8'h00, borrow_in};
  assign low_diff  = {1'b0, wreg[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, borrow_in};
  assign dec_v     = mem_byte - `RSSA_ONE_BYTE;
  assign inc_v     = mem_byte + `RSSA_ONE_BYTE;
  assign bit_mask  = `RSSA_ONE_BYTE << bit_sel;

  always_comb
  begin
    res       = '0;
    res.flags = flags;
    case (op)
      rssa_pkg::OP_ROTL_CY, rssa_pkg::OP_ROTL_CY_COPY:
      begin
        res.data    = {mem_byte[6:0], flags.c}; // RQ1
        res.flags.c = mem_byte[7];
        res.c_we    = 1'b1;
        res.to_mem  = (op == rssa_pkg::OP_ROTL_CY);
        res.to_wreg = (op == rssa_pkg::OP_ROTL_CY_COPY); // RQ2
      end
      rssa_pkg::OP_ROTL_COPY:
      begin
        res.data    = {mem_byte[6:0], mem_byte[7]}; // RQ3 RQ26
        res.to_wreg = 1'b1;
      end
      rssa_pkg::OP_ROTR, rssa_pkg::OP_ROTR_COPY:
      begin
        res.data    = {mem_byte[0], mem_byte[7:1]}; // RQ4
        res.to_mem  = (op == rssa_pkg::OP_ROTR);
        res.to_wreg = (op == rssa_pkg::OP_ROTR_COPY); // RQ5
      end
      rssa_pkg::OP_ROTR_CY, rssa_pkg::OP_ROTR_CY_COPY:
      begin
        res.data    = {flags.c, mem_byte[7:1]}; // RQ6
        res.flags.c = mem_byte[0];
        res.c_we    = 1'b1;
        res.to_mem  = (op == rssa_pkg::OP_ROTR_CY);
        res.to_wreg = (op == rssa_pkg::OP_ROTR_CY_COPY); // RQ7
      end
      rssa_pkg::OP_SUB_BORROW_W, rssa_pkg::OP_SUB_BORROW_M, rssa_pkg::OP_MINUS_W,
      rssa_pkg::OP_MINUS_M, rssa_pkg::OP_MINUS_IMM:
      begin
        res.data     = diff[7:0];
        res.to_mem   = (op == rssa_pkg::OP_SUB_BORROW_M) || (op == rssa_pkg::OP_MINUS_M); // RQ9 RQ10
        res.to_wreg  = ~res.to_mem;
        res.all_we   = 1'b1; // RQ13
        res.flags.c  = ~diff[8]; // RQ12
        res.flags.z  = (diff[7:0] == 8'h00);
        res.flags.ac = ~low_diff[4];
        res.flags.ov = (wreg[7] ^ sub_b[7]) & (wreg[7] ^ diff[7]);
      end
      rssa_pkg::OP_DEC_SKZ, rssa_pkg::OP_DEC_SKZ_COPY:
      begin
        res.data    = dec_v; // RQ14
        res.skip    = (dec_v == 8'h00);
        res.to_mem  = (op == rssa_pkg::OP_DEC_SKZ);
        res.to_wreg = (op == rssa_pkg::OP_DEC_SKZ_COPY); // RQ15
      end
      rssa_pkg::OP_INC_SKZ, rssa_pkg::OP_INC_SKZ_COPY:
      begin
        res.data    = inc_v; // RQ16
        res.skip    = (inc_v == 8'h00);
        res.to_mem  = (op == rssa_pkg::OP_INC_SKZ);
        res.to_wreg = (op == rssa_pkg::OP_INC_SKZ_COPY); // RQ17
      end
      rssa_pkg::OP_SKIP_BIT_NZ:
      begin
        res.skip = |(mem_byte & bit_mask); // RQ18
      end
      rssa_pkg::OP_SKIP_Z, rssa_pkg::OP_SKIP_Z_COPY:
      begin
        res.data    = mem_byte;
        res.skip    = (mem_byte == 8'h00); // RQ19
        res.to_wreg = (op == rssa_pkg::OP_SKIP_Z_COPY); // RQ25
      end
      rssa_pkg::OP_FILL_ONES:
      begin
        res.data   = `RSSA_FILL_BYTE; // RQ21
        res.to_mem = 1'b1;
      end
      rssa_pkg::OP_BIT_FILL_ONE:
      begin
        res.data   = mem_byte | bit_mask; // RQ21 RQ22
        res.to_mem = 1'b1;
      end
      rssa_pkg::OP_NIB_X, rssa_pkg::OP_NIB_X_COPY:
      begin
        res.data    = {mem_byte[3:0], mem_byte[7:4]}; // RQ23
        res.to_mem  = (op == rssa_pkg::OP_NIB_X);
        res.to_wreg = (op == rssa_pkg::OP_NIB_X_COPY); // RQ24
      end
      default:
      begin
        res.data = mem_byte;
      end
    endcase
  end

endmodule // rssa_alu

`default_nettype wire

// ---- hw/rssa_params.svh ----
// constants of the rotate/subtract/skip datapath: offsets, fields, resets
`ifndef RSSA_PARAMS_SVH
`define RSSA_PARAMS_SVH

`define RSSA_ADDR_W        12
`define RSSA_OFF_INSTR     12'h000
`define RSSA_OFF_WREG      12'h004
`define RSSA_OFF_FLAGS     12'h008
`define RSSA_OFF_STATUS    12'h00C
`define RSSA_MEM_BASE      12'h100
`define RSSA_MEM_END       12'h280
`define RSSA_MEM_DEPTH     96
`define RSSA_MEM_LAST      7'h5F

`define RSSA_INSTR_OP_LSB  0
`define RSSA_INSTR_OP_MSB  4
`define RSSA_INSTR_BIT_LSB 5
`define RSSA_INSTR_BIT_MSB 7
`define RSSA_INSTR_ADR_LSB 8
`define RSSA_INSTR_ADR_MSB 14
`define RSSA_INSTR_IMM_LSB 16
`define RSSA_INSTR_IMM_MSB 23

`define RSSA_FLAG_C        0
`define RSSA_FLAG_Z        1
`define RSSA_FLAG_AC       2
`define RSSA_FLAG_OV       3

`define RSSA_STAT_BUSY     0
`define RSSA_STAT_SKIP     1
`define RSSA_STAT_CNT_LSB  8
`define RSSA_STAT_CNT_MSB  15

`define RSSA_WREG_RST      8'h00
`define RSSA_FLAGS_RST     4'h0
`define RSSA_CNT_RST       8'h00
`define RSSA_FILL_BYTE     8'hFF
`define RSSA_ONE_BYTE      8'h01
`define RSSA_RESP_OKAY     2'h0
`define RSSA_RESP_SLVERR   2'h2

`endif

// ---- hw/rssa_pkg.sv ----
// types of the rotate/subtract/skip datapath
package rssa_pkg;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_ROTL_CY,
    OP_ROTL_CY_COPY,
    OP_ROTL_COPY,
    OP_ROTR,
    OP_ROTR_COPY,
    OP_ROTR_CY,
    OP_ROTR_CY_COPY,
    OP_SUB_BORROW_W,
    OP_SUB_BORROW_M,
    OP_MINUS_W,
    OP_MINUS_M,
    OP_MINUS_IMM,
    OP_DEC_SKZ,
    OP_DEC_SKZ_COPY,
    OP_INC_SKZ,
    OP_INC_SKZ_COPY,
    OP_SKIP_BIT_NZ,
    OP_SKIP_Z,
    OP_SKIP_Z_COPY,
    OP_FILL_ONES,
    OP_BIT_FILL_ONE,
    OP_NIB_X,
    OP_NIB_X_COPY
  } rssa_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_DUMMY
  } rssa_state_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [6:0] addr;
    logic [2:0] bit_sel;
    rssa_op_t   op;
  } rssa_instr_t;

  typedef struct packed {
    logic ov;
    logic ac;
    logic z;
    logic c;
  } rssa_flags_t;

  typedef struct packed {
    logic [7:0]  data;
    logic        to_mem;
    logic        to_wreg;
    logic        c_we;
    logic        all_we;
    rssa_flags_t flags;
    logic        skip;
  } rssa_alu_res_t;

endpackage

// ---- hw/rssa_top.sv ----
// rotate/subtract/skip datapath behind an AXI4-Lite register window
//
// Contract
// [RQ1] rotate left via carry writes memory
// [RQ2] rotate left via carry into working register
// [RQ3] plain left rotate copies into working register
// [RQ4] plain right rotate writes memory, no flags
// [RQ5] plain right rotate copies into working register
// [RQ6] rotate right via carry writes memory
// [RQ7] rotate right via carry into working register
// [RQ8] subtract with borrow into working register
// [RQ9] subtract with borrow into memory byte
// [RQ10] plain subtract into register or memory
// [RQ11] subtract immediate operand from working register
// [RQ12] carry clear on borrow, set otherwise
// [RQ13] subtracts update overflow, zero, half, carry
// [RQ14] decrement memory, skip when zero
// [RQ15] decrement copy to register, skip on zero
// [RQ16] increment memory, skip when wrapped zero
// [RQ17] increment copy to register, skip on zero
// [RQ18] skip when selected memory bit set
// [RQ19] skip when whole byte zero
// [RQ20] taken skip adds one dummy cycle
// [RQ21] fill byte ones or set one bit
// [RQ22] bit set keeps other seven bits
// [RQ23] nibble exchange writes memory back
// [RQ24] nibble exchange copies into working register
// [RQ25] copy byte to register, skip if zero
// [RQ26] left copy rotate excludes the carry
// [RQ27] eight-bit paths, one cycle unless skipping
`timescale 1ns/1ps
`default_nettype none
`include "rssa_params.svh"

module rssa_top
(
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic [`RSSA_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`RSSA_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic                         exec_busy,
  output logic                         dummy_slot
);

  // data memory is not reset: its content is program state, not control
  logic [7:0]              mem [0:`RSSA_MEM_DEPTH-1];
  logic [7:0]              wreg;
  rssa_pkg::rssa_flags_t   flags;
  rssa_pkg::rssa_state_t   state;
  rssa_pkg::rssa_state_t   next_state;
  rssa_pkg::rssa_instr_t   instr;
  rssa_pkg::rssa_instr_t   new_instr;
  rssa_pkg::rssa_alu_res_t res;
  logic                    last_skip;
  logic [7:0]              skip_count;

  logic                    aw_held;
  logic [`RSSA_ADDR_W-1:0] aw_addr;
  logic                    w_held;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;

  // an address hits the memory window when aligned and inside it
  function automatic logic is_mem(input logic [`RSSA_ADDR_W-1:0] a);
    is_mem = (a >= `RSSA_MEM_BASE) && (a < `RSSA_MEM_END) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [6:0] mem_index(input logic [`RSSA_ADDR_W-1:0] a);
    logic [`RSSA_ADDR_W-1:0] off;
    off       = a - `RSSA_MEM_BASE;
    mem_index = off[8:2];
  endfunction

  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire ar_hs  = s_axi_arvalid & s_axi_arready;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire r_done = s_axi_rvalid & s_axi_rready;
  wire busy   = (state != rssa_pkg::ST_IDLE);

  // write decode
  wire do_write   = aw_held & w_held & ~s_axi_bvalid;
  wire wr_instr   = (aw_addr == `RSSA_OFF_INSTR);
  wire wr_wreg    = (aw_addr == `RSSA_OFF_WREG);
  wire wr_flags   = (aw_addr == `RSSA_OFF_FLAGS);
  wire wr_mem     = is_mem(aw_addr);
  wire wr_mapped  = wr_instr | wr_wreg | wr_flags | wr_mem;
  wire instr_ok   = (new_instr.addr <= `RSSA_MEM_LAST);
  // writes during execution are refused so software never races the datapath
  wire wr_err     = busy | ~wr_mapped | (wr_instr & ~instr_ok);
  wire wr_go      = do_write & ~wr_err & w_strb[0];
  wire [6:0] wr_idx = mem_index(aw_addr);

  assign new_instr.op      = rssa_pkg::rssa_op_t'(w_data[`RSSA_INSTR_OP_MSB:`RSSA_INSTR_OP_LSB]);
  assign new_instr.bit_sel = w_data[`RSSA_INSTR_BIT_MSB:`RSSA_INSTR_BIT_LSB];
  assign new_instr.addr    = w_data[`RSSA_INSTR_ADR_MSB:`RSSA_INSTR_ADR_LSB];
  assign new_instr.imm     = w_data[`RSSA_INSTR_IMM_MSB:`RSSA_INSTR_IMM_LSB];

  wire launch = wr_go & wr_instr;

  // read decode
  wire rd_instr  = (s_axi_araddr == `RSSA_OFF_INSTR);
  wire rd_wreg   = (s_axi_araddr == `RSSA_OFF_WREG);
  wire rd_flags  = (s_axi_araddr == `RSSA_OFF_FLAGS);
  wire rd_status = (s_axi_araddr == `RSSA_OFF_STATUS);
  wire rd_mem    = is_mem(s_axi_araddr);
  wire rd_ok     = rd_instr | rd_wreg | rd_flags | rd_status | rd_mem;
  wire [6:0] rd_idx = mem_index(s_axi_araddr);

  logic [31:0] status_word;
  logic [31:0] instr_word;
  logic [31:0] rd_word;

  always_comb
  begin
    status_word = '0;
    status_word[`RSSA_STAT_BUSY] = busy;
    status_word[`RSSA_STAT_SKIP] = last_skip;
    status_word[`RSSA_STAT_CNT_MSB:`RSSA_STAT_CNT_LSB] = skip_count;
  end

  always_comb
  begin
    instr_word = '0;
    instr_word[`RSSA_INSTR_OP_MSB:`RSSA_INSTR_OP_LSB]   = instr.op;
    instr_word[`RSSA_INSTR_BIT_MSB:`RSSA_INSTR_BIT_LSB] = instr.bit_sel;
    instr_word[`RSSA_INSTR_ADR_MSB:`RSSA_INSTR_ADR_LSB] = instr.addr;
    instr_word[`RSSA_INSTR_IMM_MSB:`RSSA_INSTR_IMM_LSB] = instr.imm;
  end

  assign rd_word = rd_mem    ? {24'h000000, mem[rd_idx]} :
                   rd_wreg   ? {24'h000000, wreg} :
                   rd_flags  ? {28'h0000000, flags} :
                   rd_status ? status_word :
                   rd_instr  ? instr_word : 32'h00000000;

  // execution datapath
  wire [7:0] op_byte = mem[instr.addr];
  wire       in_exec = (state == rssa_pkg::ST_EXEC);
  wire       skip    = in_exec & res.skip;

  rssa_alu u_alu
  (
    .mem_byte (op_byte),
    .wreg     (wreg),
    .imm      (instr.imm),
    .bit_sel  (instr.bit_sel),
    .op       (instr.op),
    .flags    (flags),
    .res      (res)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      rssa_pkg::ST_IDLE:
      begin
        if (launch)
          next_state = rssa_pkg::ST_EXEC;
      end
      rssa_pkg::ST_EXEC:
      begin
        // no skip: the instruction ends after its single cycle
        if (res.skip)
          next_state = rssa_pkg::ST_DUMMY; // RQ20
        else
          next_state = rssa_pkg::ST_IDLE; // RQ27
      end
      rssa_pkg::ST_DUMMY:
      begin
        next_state = rssa_pkg::ST_IDLE; // RQ20
      end
      default:
      begin
        next_state = rssa_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      state <= rssa_pkg::ST_IDLE;
    else if (ce)
      state <= next_state;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      instr <= '0;
    else if (ce && launch)
      instr <= new_instr;
  end

  // one port: the datapath and software never write in the same cycle
  always_ff @(posedge clock)
  begin
    if (ce && in_exec && res.to_mem)
      mem[instr.addr] <= res.data; // RQ1 RQ4 RQ6 RQ9 RQ14 RQ16 RQ21 RQ23
    else if (ce && wr_go && wr_mem)
      mem[wr_idx] <= w_data[7:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      wreg <= `RSSA_WREG_RST;
    else if (ce && in_exec && res.to_wreg)
      wreg <= res.data; // RQ2 RQ3 RQ5 RQ7 RQ8 RQ15 RQ17 RQ24 RQ25
    else if (ce && wr_go && wr_wreg)
      wreg <= w_data[7:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      flags <= `RSSA_FLAGS_RST;
    else if (ce && in_exec && res.all_we)
      flags <= res.flags; // RQ12 RQ13
    else if (ce && in_exec && res.c_we)
      flags.c <= res.flags.c; // RQ1 RQ6
    else if (ce && wr_go && wr_flags)
      flags <= w_data[3:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      last_skip  <= 1'b0;
      skip_count <= `RSSA_CNT_RST;
    end
    else if (ce && in_exec)
    begin
      last_skip <= res.skip;
      if (skip)
        skip_count <= skip_count + `RSSA_ONE_BYTE;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      exec_busy  <= 1'b0;
      dummy_slot <= 1'b0;
    end
    else if (ce)
    begin
      exec_busy  <= (next_state != rssa_pkg::ST_IDLE);
      dummy_slot <= (next_state == rssa_pkg::ST_DUMMY); // RQ20
    end
  end

  // write address and data are caught independently, in either order
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (ce)
    begin
      if (aw_hs)
      begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else
      begin
        if (do_write)
          aw_held <= 1'b0;
        s_axi_awready <= ~aw_held & ~s_axi_bvalid & ~do_write;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end
    else if (ce)
    begin
      if (w_hs)
      begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else
      begin
        if (do_write)
          w_held <= 1'b0;
        s_axi_wready <= ~w_held & ~s_axi_bvalid & ~do_write;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RSSA_RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `RSSA_RESP_SLVERR : `RSSA_RESP_OKAY;
      end
      else if (b_done)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RSSA_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `RSSA_RESP_OKAY : `RSSA_RESP_SLVERR;
      end
      else
      begin
        if (r_done)
          s_axi_rvalid <= 1'b0;
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end

endmodule // rssa_top

`default_nettype wire

// ---- tb/rotate_subtract_skip_alu_tb_top.sv ----
// self-checking bench of the rotate/subtract/skip datapath
`timescale 1ns/1ps
`default_nettype none
`include "rssa_params.svh"

module rotate_subtract_skip_alu_tb_top;
  logic        clock = 1'h0;
  logic        srst = 1'h1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        arvalid = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, busy, dummy;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          busy_cnt = 0;
  int          dummy_cnt = 0;

  rssa_top uut
  (
    .clock         (clock),
    .srst          (srst),
    .ce            (1'h1),
    .s_axi_awaddr  (awaddr),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (4'hF),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (1'h1),
    .s_axi_araddr  (araddr),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (1'h1),
    .exec_busy     (busy),
    .dummy_slot    (dummy)
  );

  always #10 clock = ~clock;

  // cycle counts of busy and dummy give the instruction length seen at the pins
  always @(posedge clock)
  begin
    cycles++;
    if (busy === 1'h1)
      busy_cnt++;
    if (dummy === 1'h1)
      dummy_cnt++;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop;
    end
  end

  task report_and_stop;
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bready and rready stay high, so each answer is taken where it first shows
  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(ad && wd))
    begin
      @(posedge clock);
      ad = ad || awready;
      wd = wd || wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge clock); while (bvalid !== 1'h1);
    r = bresp;
  endtask

  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clock); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
  endtask

  task put(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check(32'(r), 32'(`RSSA_RESP_OKAY));
  endtask

  task get(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, exp);
    check(32'(r), 32'(`RSSA_RESP_OKAY));
  endtask

  task run(input int op, input logic [2:0] bs, input logic [6:0] ix, input logic [7:0] im, m, w,
           input logic [3:0] f, input logic [7:0] em, ew, input logic [3:0] ef, input logic sk);
    logic [31:0] s0, s1;
    logic [1:0]  r;
    int          b0, d0, n;
    put(`RSSA_MEM_BASE + {3'h0, ix, 2'h0}, {24'h0, m});
    put(`RSSA_OFF_WREG, {24'h0, w});
    put(`RSSA_OFF_FLAGS, {28'h0, f});
    rd(`RSSA_OFF_STATUS, s0, r);
    b0 = busy_cnt;
    d0 = dummy_cnt;
    put(`RSSA_OFF_INSTR, {8'h0, im, 1'h0, ix, bs, op[4:0]});
    n = 0;
    s1 = 32'h1;
    while (s1[0] !== 1'h0 && n < 20)
    begin
      rd(`RSSA_OFF_STATUS, s1, r);
      n++;
    end
    check(32'(s1[1]), 32'(sk));
    check(32'(s1[15:8]), 32'(s0[15:8] + 8'(sk)));
    check(32'(dummy_cnt - d0), 32'(sk));
    check(32'(busy_cnt - b0), 32'(1 + int'(sk)));
    get(`RSSA_OFF_INSTR, {8'h0, im, 1'h0, ix, bs, op[4:0]});
    get(`RSSA_MEM_BASE + {3'h0, ix, 2'h0}, {24'h0, em});
    get(`RSSA_OFF_WREG, {24'h0, ew});
    get(`RSSA_OFF_FLAGS, {28'h0, ef});
  endtask

  task t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    int          b0;
    get(`RSSA_OFF_WREG, 32'h0);
    get(`RSSA_OFF_FLAGS, 32'h0);
    get(`RSSA_OFF_STATUS, 32'h0);
    rd(12'h010, d, r);
    check(32'(r), 32'(`RSSA_RESP_SLVERR));
    check(d, 32'h0);
    wr(`RSSA_OFF_STATUS, 32'h1, r);
    check(32'(r), 32'(`RSSA_RESP_SLVERR));
    b0 = busy_cnt;
    wr(`RSSA_OFF_INSTR, {16'h0, 1'h0, 7'h60, 8'h01}, r);
    check(32'(r), 32'(`RSSA_RESP_SLVERR));
    check(32'(busy_cnt - b0), 32'h0);
  endtask

  task t_rotate;
    logic [7:0] m, em, ew;
    logic       c, ec;
    for (int k = 0; k < 4; k++)
      for (int op = 1; op < 8; op++)
      begin
        m = k[1] ? 8'h81 : 8'h4E;
        c = k[0];
        em = m;
        ew = 8'h5A;
        ec = c;
        case (op)
          1: {ec, em} = {m, c};
          2: {ec, ew} = {m, c};
          3: ew = {m[6:0], m[7]};
          4: em = {m[0], m[7:1]};
          5: ew = {m[0], m[7:1]};
          6: {em, ec} = {c, m};
          default: {ew, ec} = {c, m};
        endcase
        run(op, 3'h0, 7'h00, 8'h00, m, 8'h5A, {3'h5, c}, em, ew, {3'h5, ec}, 1'h0);
      end
  endtask

  // vectors avoid results where the borrow-in alone would flip the overflow
  task automatic t_sub;
    logic [7:0] wv [5] = '{8'h80, 8'h05, 8'h10, 8'h00, 8'h7F};
    logic [7:0] bv [5] = '{8'h01, 8'h05, 8'h01, 8'h01, 8'hFE};
    logic [8:0] df;
    logic [4:0] nb;
    logic [7:0] w, b, mv;
    logic       bi, ov, tm;
    for (int k = 0; k < 10; k++)
      for (int op = 8; op < 13; op++)
      begin
        w = wv[k / 2];
        b = bv[k / 2];
        bi = (op < 10) && !k[0];
        df = {1'h0, w} - {1'h0, b} - 9'(bi);
        nb = {1'h0, w[3:0]} - {1'h0, b[3:0]} - 5'(bi);
        ov = (w[7] != b[7]) && (df[7] != w[7]);
        tm = (op == 9) || (op == 11);
        mv = (op == 12) ? 8'h33 : b;
        run(op, 3'h0, 7'h28, b, mv, w, {3'h2, k[0]}, tm ? df[7:0] : mv, tm ? w : df[7:0],
            {ov, !nb[4], df[7:0] == 8'h00, !df[8]}, 1'h0);
      end
  endtask

  task automatic t_skip;
    logic [7:0] mv [4] = '{8'h01, 8'h00, 8'hFF, 8'h08};
    logic [7:0] m, r, em, ew;
    logic       sk;
    for (int k = 0; k < 4; k++)
      for (int op = 13; op < 20; op++)
      begin
        m = mv[k];
        r = (op < 15) ? m - 8'h01 : m + 8'h01;
        em = m;
        ew = 8'hC3;
        sk = (r == 8'h00);
        case (op)
          13, 15: em = r;
          14, 16: ew = r;
          17: sk = m[3];
          18: sk = (m == 8'h00);
          default:
          begin
            ew = m;
            sk = (m == 8'h00);
          end
        endcase
        run(op, 3'h3, 7'h5F, 8'h00, m, 8'hC3, 4'h9, em, ew, 4'h9, sk);
      end
  endtask

  task t_fill;
    run(20, 3'h0, 7'h01, 8'h00, 8'h5A, 8'h11, 4'h6, 8'hFF, 8'h11, 4'h6, 1'h0);
    for (int i = 0; i < 8; i++)
      run(21, 3'(i), 7'h01, 8'h00, 8'h5A, 8'h11, 4'h6, 8'h5A | (8'h01 << i), 8'h11, 4'h6, 1'h0);
    run(22, 3'h0, 7'h02, 8'h00, 8'h2D, 8'h11, 4'h6, 8'hD2, 8'h11, 4'h6, 1'h0);
    run(23, 3'h0, 7'h02, 8'h00, 8'h2D, 8'h11, 4'h6, 8'h2D, 8'hD2, 4'h6, 1'h0);
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    t_reset;
    t_rotate;
    t_sub;
    t_skip;
    t_fill;
    report_and_stop;
  end
endmodule // rotate_subtract_skip_alu_tb_top
`default_nettype wire

// ---- tb/rssa_top_monitor.sv ----
// assertion checker for the datapath's bus handshakes and execution timing
`timescale 1ns/1ps
`default_nettype none
`include "rssa_params.svh"

module rssa_top_monitor
(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_rvalid,
  input wire logic       exec_busy,
  input wire logic       dummy_slot
);
  // ce low freezes every flop, so durations are only judged while it runs
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst || !ce);

  AST_DUMMY_SINGLE: assert property (dummy_slot |=> !dummy_slot)
    else $error("dummy slot lasted more than one cycle");
  AST_DUMMY_IN_BUSY: assert property (dummy_slot |-> exec_busy)
    else $error("dummy slot outside busy");
  AST_DUMMY_AFTER_EXEC: assert property ($rose(dummy_slot) |-> $past(exec_busy))
    else $error("dummy slot without a preceding execute cycle");
  AST_EXEC_LENGTH: assert property ($rose(exec_busy) |=>
      (!exec_busy && !dummy_slot) or (dummy_slot ##1 !exec_busy))
    else $error("execution not one cycle, or two with a skip");
  AST_EXEC_AT_RESP: assert property ($rose(exec_busy) |->
      s_axi_bvalid && s_axi_bresp == `RSSA_RESP_OKAY)
    else $error("execution started without an accepted write");
  AST_AW_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while a response is pending");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");
  AST_RESET_QUIET: assert property ($past(srst) |->
      !exec_busy && !dummy_slot && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active just after reset");
endmodule // rssa_top_monitor

bind rssa_top rssa_top_monitor mon (.clock(clock), .srst(srst), .ce(ce),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .exec_busy(exec_busy), .dummy_slot(dummy_slot));
`default_nettype wire
